// *** hdl/pmc_pkg.sv ***
// Package: constants for the CPU power mode control block
// Operation
// - Two software states, Idle and Stop, each entered by writing a control bit.
// - Idle halts instruction execution; peripherals and system clocks keep running.
// - Stop halts CPU, masks all interrupts and stops the internal oscillator.
// - Stop leaves analog enables and external oscillator untouched.
// - With oscillators off, execution resumes only after a reset.
// - Suspend holds the internal oscillator stopped until a non-idle USB event.
// - Suspend also ends when bus-power level equals the selected polarity.
// - Idle starts only after the writing instruction has completed.
// - All registers and memory hold their contents throughout Idle.
// - Idle ends only on an enabled interrupt or a reset.
// - Interrupt wake clears the idle bit in hardware and resumes the CPU.
// - Interrupt wake services the interrupt, then continues after the idle write.
// - Reset wake runs the normal reset sequence from the reset vector.
// - Enabled watchdog timeout during Idle raises a reset that ends Idle.
// - Stop starts only after the writing instruction has completed.
// - Stop ends only on a reset, then runs from the reset vector.
// - Idle and stop select bits always read as zero.
package pmc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] PMC_ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] PMC_ADDR_REGULATOR_CTRL = 8'h88;
  localparam logic [7:0] PMC_ADDR_STATUS = 8'h89;
  localparam int PMC_BIT_IDLE = 0;
  localparam int PMC_BIT_STOP = 1;
  localparam int PMC_BIT_VBUS_POL = 0;
  localparam int PMC_BIT_SUSPEND = 1;
  localparam logic [7:0] PMC_RESET_POWER_CONTROL = 8'h00;
  localparam logic [7:0] PMC_RESET_REGULATOR_CTRL = 8'h00;
  localparam logic [15:0] PMC_RESET_VECTOR = 16'h0000;
  localparam logic [7:0] PMC_UNMAPPED_READ = 8'h00;
  // ----------------------------------------
  // Modes
  // ----------------------------------------
  typedef enum logic [1:0] {PMC_RUN, PMC_IDLE, PMC_STOP} pmc_mode_e;
endpackage

// *** hdl/pmc_osc_suspend.sv ***
// Internal oscillator suspend control
`timescale 1ns/1ps
`default_nettype none
module pmc_osc_suspend
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic suspend_req,
  input  wire logic vbus_polarity_select,
  // Wake sources
  input  wire logic usb_resume_event,
  input  wire logic vbus_level,
  // Status
  output logic      osc_run
);
  import pmc_pkg::*;

  logic wake;

  // ----------------------------------------
  // Wake detect
  // ----------------------------------------
  assign wake = usb_resume_event | (vbus_level == vbus_polarity_select);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      osc_run <= 1'b1;
    else if (!osc_run && wake)
      osc_run <= 1'b1;
    else if (suspend_req && !wake)
      osc_run <= 1'b0;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_susp_wake;
    @(posedge clk) disable iff (rst)
    (!osc_run && usb_resume_event) |=> osc_run;
  endproperty
  a_susp_wake: assert property (p_susp_wake) else $error("usb event did not restart oscillator");

  property p_susp_vbus;
    @(posedge clk) disable iff (rst)
    (!osc_run && vbus_level == vbus_polarity_select) |=> osc_run;
  endproperty
  a_susp_vbus: assert property (p_susp_vbus) else $error("vbus match did not restart oscillator");

  property p_susp_hold;
    @(posedge clk) disable iff (rst)
    (!osc_run && !wake) |=> !osc_run;
  endproperty
  a_susp_hold: assert property (p_susp_hold) else $error("oscillator restarted without wake");
endmodule
`default_nettype wire

// *** hdl/pmc_top.sv ***
// CPU power mode control: idle, stop and oscillator suspend
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module pmc_top
(
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RST,
  // Register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // CPU handshake
  input  wire logic       INSTR_DONE,
  input  wire logic       IRQ_ENABLED_PENDING,
  input  wire logic       WATCHDOG_TIMEOUT,
  input  wire logic       WATCHDOG_ENABLE,
  // USB suspend wake
  input  wire logic       USB_RESUME_EVENT,
  input  wire logic       VBUS_LEVEL,
  // Core control
  output logic            CPU_CLK_EN,
  output logic            IRQ_GATE,
  output logic            INT_OSC_RUN,
  output logic            WATCHDOG_RESET,
  output logic            RESTART_FETCH,
  output logic     [15:0] FETCH_VECTOR,
  output logic      [1:0] MODE
);
  import pmc_pkg::*;

  pmc_mode_e mode;
  logic      idle_pend;
  logic      stop_pend;
  logic [7:0] regulator_control_reg;
  logic [5:0] gp_flags;
  logic      osc_run;
  logic      osc_stop_req;
  logic      wr_power_control_reg;
  logic      sync_reset;
  logic      rst_seen;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  assign wr_power_control_reg = WR && hit(ADDR, PMC_ADDR_POWER_CONTROL);
  // Watchdog reset returns the mode sequencer to run and restarts fetch; unlike RST it leaves the registers untouched
  assign sync_reset = WATCHDOG_RESET;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      regulator_control_reg <= PMC_RESET_REGULATOR_CTRL;
      gp_flags <= 6'h00;
    end
    else
    begin
      // Settings survive idle untouched; only bus writes change them
      if (WR && hit(ADDR, PMC_ADDR_REGULATOR_CTRL))
        regulator_control_reg <= WDATA;
      if (wr_power_control_reg)
        gp_flags <= WDATA[7:2];
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      RDATA <= 8'h00;
    else if (RD)
    begin
      if (hit(ADDR, PMC_ADDR_POWER_CONTROL))
        RDATA <= {gp_flags, 2'b00};
      else if (hit(ADDR, PMC_ADDR_REGULATOR_CTRL))
        RDATA <= regulator_control_reg;
      else if (hit(ADDR, PMC_ADDR_STATUS))
        RDATA <= {5'h00, osc_run, mode};
      else
        RDATA <= PMC_UNMAPPED_READ;
    end
    else
      RDATA <= 8'h00;
  end

  // ----------------------------------------
  // Mode sequencing
  // ----------------------------------------
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      mode <= PMC_RUN;
      idle_pend <= 1'b0;
      stop_pend <= 1'b0;
    end
    else if (sync_reset)
    begin
      mode <= PMC_RUN;
      idle_pend <= 1'b0;
      stop_pend <= 1'b0;
    end
    else
    begin
      unique case (mode)
        PMC_RUN:
        begin
          if (wr_power_control_reg && WDATA[PMC_BIT_STOP])
            stop_pend <= 1'b1;
          else if (wr_power_control_reg && WDATA[PMC_BIT_IDLE])
            idle_pend <= 1'b1;
          // Pending bits wait for the writing instruction to retire
          if ((stop_pend || (wr_power_control_reg && WDATA[PMC_BIT_STOP])) && INSTR_DONE)
          begin
            mode <= PMC_STOP;
            stop_pend <= 1'b0;
            idle_pend <= 1'b0;
          end
          else if ((idle_pend || (wr_power_control_reg && WDATA[PMC_BIT_IDLE])) && INSTR_DONE)
          begin
            mode <= PMC_IDLE;
            idle_pend <= 1'b0;
          end
        end
        PMC_IDLE:
          if (IRQ_ENABLED_PENDING)
            mode <= PMC_RUN;
        PMC_STOP:
          mode <= PMC_STOP;
        default:
          mode <= PMC_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // Watchdog and reset vector
  // ----------------------------------------
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      WATCHDOG_RESET <= 1'b0;
    else
      WATCHDOG_RESET <= WATCHDOG_ENABLE && WATCHDOG_TIMEOUT && !WATCHDOG_RESET;
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      rst_seen <= 1'b1;
      RESTART_FETCH <= 1'b0;
      FETCH_VECTOR <= PMC_RESET_VECTOR;
    end
    else
    begin
      rst_seen <= sync_reset;
      RESTART_FETCH <= rst_seen;
      FETCH_VECTOR <= PMC_RESET_VECTOR;
    end
  end

  // ----------------------------------------
  // Core gating outputs
  // ----------------------------------------
  assign osc_stop_req = regulator_control_reg[PMC_BIT_SUSPEND];

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      CPU_CLK_EN <= 1'b1;
      IRQ_GATE <= 1'b1;
      MODE <= 2'b00;
      INT_OSC_RUN <= 1'b1;
    end
    else
    begin
      CPU_CLK_EN <= (mode == PMC_RUN) && !sync_reset;
      IRQ_GATE <= (mode != PMC_STOP);
      MODE <= mode;
      // Stop kills the oscillator regardless of suspend wake sources
      INT_OSC_RUN <= osc_run && (mode != PMC_STOP);
    end
  end

  pmc_osc_suspend u_suspend
  (
    .clk                  (CLOCK),
    .rst                  (RST),
    .suspend_req          (osc_stop_req),
    .vbus_polarity_select (regulator_control_reg[PMC_BIT_VBUS_POL]),
    .usb_resume_event     (USB_RESUME_EVENT),
    .vbus_level           (VBUS_LEVEL),
    .osc_run              (osc_run)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_idle_entry;
    @(posedge CLOCK) disable iff (RST)
    (mode == PMC_RUN && wr_power_control_reg && WDATA[1:0] == 2'b01 && !INSTR_DONE && !sync_reset) |=> mode == PMC_RUN;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle entered before instruction done");

  property p_idle_go;
    @(posedge CLOCK) disable iff (RST)
    (mode == PMC_RUN && wr_power_control_reg && WDATA[1:0] == 2'b01 && INSTR_DONE && !sync_reset) |=> mode == PMC_IDLE;
  endproperty
  a_idle_go: assert property (p_idle_go) else $error("idle not entered");

  property p_stop_first;
    @(posedge CLOCK) disable iff (RST)
    (mode == PMC_RUN && wr_power_control_reg && WDATA[1:0] == 2'b11 && INSTR_DONE && !sync_reset) |=> mode == PMC_STOP;
  endproperty
  a_stop_first: assert property (p_stop_first) else $error("stop lacks precedence");

  property p_idle_wake;
    @(posedge CLOCK) disable iff (RST)
    (mode == PMC_IDLE && IRQ_ENABLED_PENDING) |=> mode == PMC_RUN ##1 CPU_CLK_EN;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("interrupt did not end idle");

  property p_idle_hold;
    @(posedge CLOCK) disable iff (RST)
    (mode == PMC_IDLE && !IRQ_ENABLED_PENDING && !sync_reset) |=> mode == PMC_IDLE;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle left without cause");

  property p_stop_hold;
    @(posedge CLOCK) disable iff (RST)
    (mode == PMC_STOP && !sync_reset) |=> mode == PMC_STOP;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");

  property p_stop_out;
    @(posedge CLOCK) disable iff (RST)
    (mode == PMC_STOP) |=> (!CPU_CLK_EN && !IRQ_GATE && !INT_OSC_RUN);
  endproperty
  a_stop_out: assert property (p_stop_out) else $error("stop outputs wrong");

  property p_wdt;
    @(posedge CLOCK) disable iff (RST)
    (WATCHDOG_ENABLE && WATCHDOG_TIMEOUT && !WATCHDOG_RESET) |=> WATCHDOG_RESET ##1 mode == PMC_RUN ##1 RESTART_FETCH;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog reset not taken");

  property p_read_zero;
    @(posedge CLOCK) disable iff (RST)
    (RD && hit(ADDR, PMC_ADDR_POWER_CONTROL)) |=> RDATA[1:0] == 2'b00;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("select bits read nonzero");

  property p_wdt_pulse;
    @(posedge CLOCK) disable iff (RST)
    WATCHDOG_RESET |=> !WATCHDOG_RESET;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog reset longer than one cycle");

  property p_restart_pulse;
    @(posedge CLOCK) disable iff (RST)
    RESTART_FETCH |=> !RESTART_FETCH;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("restart pulse longer than one cycle");

  property p_vector;
    @(posedge CLOCK) disable iff (RST)
    RESTART_FETCH |-> FETCH_VECTOR == PMC_RESET_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("restart not at reset vector");

  property p_stop_pend;
    @(posedge CLOCK) disable iff (RST)
    (mode == PMC_RUN && wr_power_control_reg && WDATA[PMC_BIT_STOP] && !INSTR_DONE && !sync_reset) |=> mode == PMC_RUN;
  endproperty
  a_stop_pend: assert property (p_stop_pend) else $error("stop entered before instruction done");

  property p_idle_out;
    @(posedge CLOCK) disable iff (RST)
    (mode == PMC_IDLE) |=> (!CPU_CLK_EN && IRQ_GATE);
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("idle outputs wrong");

  property p_idle_regs;
    @(posedge CLOCK) disable iff (RST)
    (mode == PMC_IDLE && !WR) |=> $stable({regulator_control_reg, gp_flags});
  endproperty
  a_idle_regs: assert property (p_idle_regs) else $error("register changed during idle");

  property p_stop_keep;
    @(posedge CLOCK) disable iff (RST)
    (mode == PMC_STOP && !WR) |=> $stable(regulator_control_reg);
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("analog enables changed in stop");

  c_idle: cover property (@(posedge CLOCK) disable iff (RST) mode == PMC_IDLE ##1 mode == PMC_RUN);
  c_stop: cover property (@(posedge CLOCK) disable iff (RST) mode == PMC_STOP);
  c_wdt_idle: cover property (@(posedge CLOCK) disable iff (RST) mode == PMC_IDLE && WATCHDOG_RESET);
  c_susp: cover property (@(posedge CLOCK) disable iff (RST) !osc_run ##1 osc_run);
  c_stop_pend: cover property (@(posedge CLOCK) disable iff (RST) stop_pend ##1 mode == PMC_STOP);
endmodule
`default_nettype wire

// *** tb/cpu_power_mode_control_bench.sv ***
// Self-checking bench for the CPU power mode control block
`timescale 1ns/1ps
`default_nettype none
module cpu_power_mode_control_bench;
  import pmc_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic [7:0]  addr  = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        instr_done = 1'b1;
  logic        irq   = 1'b0;
  logic        wd_to = 1'b0;
  logic        wd_en = 1'b0;
  logic        usb_ev = 1'b0;
  logic        vbus  = 1'b1;
  logic [7:0]  rdata;
  logic        cpu_clk_en, irq_gate, osc_run, wd_rst, restart;
  logic [15:0] vector;
  logic [1:0]  mode;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          wd_cnt = 0;
  int          rf_cnt = 0;

  pmc_top dut_u (.CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .INSTR_DONE(instr_done), .IRQ_ENABLED_PENDING(irq), .WATCHDOG_TIMEOUT(wd_to), .WATCHDOG_ENABLE(wd_en),
    .USB_RESUME_EVENT(usb_ev), .VBUS_LEVEL(vbus), .CPU_CLK_EN(cpu_clk_en), .IRQ_GATE(irq_gate),
    .INT_OSC_RUN(osc_run), .WATCHDOG_RESET(wd_rst), .RESTART_FETCH(restart), .FETCH_VECTOR(vector), .MODE(mode));

  always #5 clock = ~clock;

  // Pulse counters; a pulse must last exactly one cycle
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (wd_rst === 1'b1) wd_cnt = wd_cnt + 1;
    if (restart === 1'b1) rf_cnt = rf_cnt + 1;
    if (cyc == 3000)
    begin
      error_cnt = error_cnt + 1;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a; rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk({24'h000000, rdata}, {24'h000000, exp});
  endtask

  task automatic do_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (12) @(posedge clock);
    rf_cnt = 0;
    rst <= 1'b0;
    wait_n(4);
    chk(rf_cnt, 1);
    chk(vector, PMC_RESET_VECTOR);
    chk({cpu_clk_en, irq_gate, osc_run, mode}, 5'b11100);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_regs();
    reg_rd(PMC_ADDR_POWER_CONTROL, PMC_RESET_POWER_CONTROL);
    reg_rd(PMC_ADDR_REGULATOR_CTRL, PMC_RESET_REGULATOR_CTRL);
    reg_rd(8'h90, PMC_UNMAPPED_READ);
  endtask

  task automatic t_idle_irq();
    instr_done <= 1'b0;
    reg_wr(PMC_ADDR_POWER_CONTROL, 8'hfd);
    wait_n(4);
    chk(mode, PMC_RUN);
    instr_done <= 1'b1;
    wait_n(4);
    chk({mode, cpu_clk_en, irq_gate, osc_run}, {PMC_IDLE, 3'b011});
    reg_rd(PMC_ADDR_POWER_CONTROL, 8'hfc);
    reg_rd(PMC_ADDR_STATUS, 8'h05);
    reg_wr(PMC_ADDR_POWER_CONTROL, 8'hfe);
    wait_n(3);
    chk(mode, PMC_IDLE);
    irq <= 1'b1;
    wait_n(3);
    irq <= 1'b0;
    chk({mode, cpu_clk_en}, {PMC_RUN, 1'b1});
    reg_rd(PMC_ADDR_POWER_CONTROL, 8'hfc);
  endtask

  task automatic t_watchdog();
    reg_wr(PMC_ADDR_POWER_CONTROL, 8'h01);
    wait_n(4);
    wd_to <= 1'b1;
    wait_n(3);
    wd_to <= 1'b0;
    chk(mode, PMC_IDLE);
    wd_cnt = 0;
    rf_cnt = 0;
    @(posedge clock);
    wd_en <= 1'b1; wd_to <= 1'b1;
    @(posedge clock);
    wd_to <= 1'b0; wd_en <= 1'b0;
    wait_n(5);
    chk(wd_cnt, 1);
    chk(rf_cnt, 1);
    chk({mode, cpu_clk_en, vector}, {PMC_RUN, 1'b1, PMC_RESET_VECTOR});
  endtask

  task automatic t_stop();
    reg_wr(PMC_ADDR_REGULATOR_CTRL, 8'h01);
    instr_done <= 1'b0;
    reg_wr(PMC_ADDR_POWER_CONTROL, 8'h03);
    wait_n(4);
    chk(mode, PMC_RUN);
    instr_done <= 1'b1;
    wait_n(4);
    chk({mode, cpu_clk_en, irq_gate, osc_run}, {PMC_STOP, 3'b000});
    irq <= 1'b1;
    reg_wr(PMC_ADDR_POWER_CONTROL, 8'h00);
    wait_n(6);
    irq <= 1'b0;
    chk({mode, cpu_clk_en}, {PMC_STOP, 1'b0});
    reg_rd(PMC_ADDR_REGULATOR_CTRL, 8'h01);
    do_reset();
    // Both bits with the instruction already done: straight into stop
    reg_wr(PMC_ADDR_POWER_CONTROL, 8'h03);
    wait_n(3);
    chk({mode, irq_gate}, {PMC_STOP, 1'b0});
    do_reset();
  endtask

  task automatic t_suspend();
    vbus <= 1'b1;
    reg_wr(PMC_ADDR_REGULATOR_CTRL, 8'h02);
    wait_n(4);
    chk(osc_run, 1'b0);
    chk(mode, PMC_RUN);
    usb_ev <= 1'b1;
    wait_n(4);
    chk(osc_run, 1'b1);
    reg_wr(PMC_ADDR_REGULATOR_CTRL, 8'h00);
    usb_ev <= 1'b0;
    vbus <= 1'b0;
    wait_n(3);
    chk(osc_run, 1'b1);
    reg_wr(PMC_ADDR_REGULATOR_CTRL, 8'h03);
    wait_n(4);
    chk(osc_run, 1'b0);
    reg_rd(PMC_ADDR_REGULATOR_CTRL, 8'h03);
    vbus <= 1'b1;
    wait_n(4);
    chk(osc_run, 1'b1);
    reg_wr(PMC_ADDR_REGULATOR_CTRL, 8'h00);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  task automatic print_verdict();
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    do_reset();
    t_reset_regs();
    t_idle_irq();
    t_watchdog();
    t_stop();
    t_suspend();
    print_verdict();
  end
endmodule
`default_nettype wire
